// ---- design/urt_defines.svh ----
/*
 * Constants of the serial port: timing, register offsets, field
 * positions and reset values.
 * Assumes a 200 MHz system clock and an 8-bit register address.
 */
`ifndef URT_DEFINES_SVH
`define URT_DEFINES_SVH

// ==========================================================
// Timing
`define URT_CLK_PERIOD_NS 5
`define URT_CLK_HZ        (1000000000 / `URT_CLK_PERIOD_NS)
`define URT_MS_NS         1000000
`define URT_MS_CYC        (`URT_MS_NS / `URT_CLK_PERIOD_NS)
`define URT_OVS_LAST      4'hF
`define URT_OVS_MID       4'h7

// ==========================================================
// Limits
`define URT_BAUD_MIN      20'h0012C
`define URT_BAUD_MAX      20'hE1000
`define URT_DLY_MAX       7'h64

// ==========================================================
// Register offsets
`define URT_A_CTRL        8'h00
`define URT_A_BAUD        8'h04
`define URT_A_RTSDLY      8'h08
`define URT_A_TXDATA      8'h0C
`define URT_A_RXDATA      8'h10
`define URT_A_STATUS      8'h14

// ==========================================================
// Fields
`define URT_CTRL_MODE     1:0
`define URT_CTRL_FLOW     3:2
`define URT_CTRL_DBITS    5:4
`define URT_CTRL_PAR      8:6
`define URT_CTRL_STOP2    9
`define URT_CTRL_FIFO     10
`define URT_DLY_ON        6:0
`define URT_DLY_OFF       22:16

// ==========================================================
// Reset values
`define URT_CTRL_RST      11'h430
`define URT_BAUD_RST      20'h02580
`define URT_DLY_RST       7'h00

`endif

// ---- design/urt_pkg.sv ----
/*
 * Types of the serial port: line modes, flow control, parity and
 * the transmit and receive states.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package urt_pkg;
  // ========================================================
  // Configuration encodings
  typedef enum logic [1:0] {
    URT_RS232, URT_RS422, URT_RS485_2W, URT_RS485_4W
  } urt_mode_t;
  typedef enum logic [1:0] {
    URT_FLOW_NONE, URT_FLOW_RTSCTS, URT_FLOW_TOGGLE, URT_FLOW_RSVD
  } urt_flow_t;
  typedef enum logic [2:0] {
    URT_PAR_NONE, URT_PAR_ODD, URT_PAR_EVEN, URT_PAR_MARK, URT_PAR_SPACE
  } urt_par_t;
  // ========================================================
  // State machines
  typedef enum logic [2:0] {
    TX_IDLE, TX_RTS_ON, TX_START, TX_DATA, TX_PAR, TX_STOP, TX_RTS_OFF
  } urt_tx_st_t;
  typedef enum logic [2:0] {
    RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP
  } urt_rx_st_t;
endpackage

// ---- design/urt_strm_if.sv ----
/*
 * Valid/ready stream carrier between the port's own modules.
 * Assumes both ends sit on the same clock.
 */
`timescale 1ns/1ps
interface urt_strm_if #(parameter int W = 8);
  logic [W-1:0] data;
  logic         valid;
  logic         ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

// ---- design/urt_fifo.sv ----
/*
 * Character FIFO with valid/ready on both sides.
 * Assumes one clock; single limits it to one entry.
 */
`timescale 1ns/1ps
module urt_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Mode
  input wire logic single,
  // Streams
  urt_strm_if.snk  in_s,
  urt_strm_if.src  out_s
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0]  wp_ff;
  logic [AW:0]  rp_ff;
  logic         full;
  logic         empty;
  logic         push;
  logic         pop;

  // ==========================================================
  // Flags
  assign empty = (wp_ff == rp_ff);
  assign full  = (wp_ff[AW] != rp_ff[AW]) &&
                 (wp_ff[AW-1:0] == rp_ff[AW-1:0]);
  // Single-entry mode trades throughput for latency
  assign in_s.ready  = !full && (!single || empty);
  assign out_s.valid = !empty;
  assign out_s.data  = mem[rp_ff[AW-1:0]];
  assign push = in_s.valid && in_s.ready;
  assign pop  = out_s.valid && out_s.ready;

  // ==========================================================
  // Pointers and storage
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wp_ff <= '0;
      rp_ff <= '0;
    end else begin
      if (push) wp_ff <= wp_ff + 1'b1;
      if (pop) rp_ff <= rp_ff + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (push) mem[wp_ff[AW-1:0]] <= in_s.data;
  end
endmodule // urt_fifo

// ---- design/urt_baud.sv ----
/*
 * Sixteen-times oversampling tick from a rate in bits per second.
 * Assumes rate stays within the supported range.
 */
`timescale 1ns/1ps
`include "urt_defines.svh"
module urt_baud (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // Rate
  input  wire logic [19:0] rate,
  // Tick
  output logic             tick_ff
);
  localparam logic [27:0] HZ = 28'(`URT_CLK_HZ);
  logic [27:0] acc_ff;
  logic [27:0] sum;
  logic        wrap;

  // ==========================================================
  // Phase accumulator; any rate works, not just standard ones
  assign sum  = acc_ff + {4'h0, rate, 4'h0};
  assign wrap = (sum >= HZ);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      acc_ff  <= '0;
      tick_ff <= 1'b0;
    end else begin
      acc_ff  <= wrap ? sum - HZ : sum;
      tick_ff <= wrap;
    end
  end
endmodule // urt_baud

// ---- design/urt_port.sv ----
/*
 * Serial port with line modes, framing, FIFOs and RTS toggle.
 * Assumes a 200 MHz clock, a one-cycle register strobe port and
 * external transceivers selected by line_mode.
 */
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "urt_defines.svh"

// Functional notes
// R1: One of four line modes per port
// R2: Any bit rate between bounds accepted
// R3: Five to eight data bits, parity, stops
// R4: Switchable buffer; off gives minimum latency
// R5: RTS toggle only in RS-232 mode
// R6: Assert RTS, wait on delay, then send
// R7: After last character wait, then drop RTS
// R8: RTS low while nothing queued
// R9: On and off delays zero to 100 ms
// R10: CTS low holds off next character
module urt_port import urt_pkg::*; #(
  parameter int MS_CYC = `URT_MS_CYC
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // Register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  output logic      [31:0] rdata,
  // Serial pins
  input  wire logic        rxd,
  input  wire logic        cts,
  output logic             txd,
  output logic             txd_oe_n,
  output logic             rts,
  output logic             rx_en_n,
  output logic      [1:0]  line_mode
);
  // ==========================================================
  // Declarations
  logic [10:0] ctrl_ff;
  logic [19:0] baud_ff;
  logic [6:0]  on_dly_ff;
  logic [6:0]  off_dly_ff;
  logic        rxd_s1_ff, rxd_s2_ff, cts_s1_ff, cts_s2_ff;
  logic        ovr_ff, perr_ff, ferr_ff, drop_ff;
  logic        nxt_ovr, nxt_perr, nxt_ferr, nxt_drop;
  logic        tick;
  urt_mode_t   mode;
  urt_flow_t   flow;
  urt_par_t    ptype;
  logic [2:0]  last_bit;
  logic        tog, cts_ok, two_wire;
  logic        sel_ctrl, sel_baud, sel_dly, sel_tx, sel_rx, sel_st;
  logic [31:0] rd_mux;
  // Transmitter
  urt_tx_st_t  tx_st_ff, nxt_tx_st;
  logic [7:0]  tx_sh_ff, nxt_tx_sh;
  logic [2:0]  tx_bit_ff, nxt_tx_bit;
  logic [3:0]  tx_ovs_ff, nxt_tx_ovs;
  logic        tx_par_ff, nxt_tx_par, tx_stp_ff, nxt_tx_stp;
  logic [6:0]  ms_ff, nxt_ms;
  logic [17:0] cyc_ff, nxt_cyc;
  logic        rtog_ff, nxt_rtog, nxt_txd, tx_pop, tx_bit_end, tx_act;
  // Receiver
  urt_rx_st_t  rx_st_ff, nxt_rx_st;
  logic [7:0]  rx_sh_ff, nxt_rx_sh;
  logic [2:0]  rx_bit_ff, nxt_rx_bit;
  logic [3:0]  rx_ovs_ff, nxt_rx_ovs;
  logic        rx_push_ff, nxt_rx_push, rx_line, rx_mid, rx_perr, rx_ferr;

  urt_strm_if #(.W(8)) tx_in ();
  urt_strm_if #(.W(8)) tx_out ();
  urt_strm_if #(.W(8)) rx_in ();
  urt_strm_if #(.W(8)) rx_out ();

  // ==========================================================
  // Functions
  function automatic logic par_bit(input logic [7:0] d,
                                   input logic [2:0] lb,
                                   input urt_par_t   pt);
    logic x;
    x = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (3'(i) <= lb) x = x ^ d[i];
    end
    case (pt)
      URT_PAR_ODD:  par_bit = ~x;
      URT_PAR_EVEN: par_bit = x;
      URT_PAR_MARK: par_bit = 1'b1;
      default:      par_bit = 1'b0;
    endcase
  endfunction

  function automatic logic [6:0] clamp_dly(input logic [6:0] v);
    clamp_dly = (v > `URT_DLY_MAX) ? `URT_DLY_MAX : v;
  endfunction

  function automatic logic [19:0] clamp_baud(input logic [19:0] v);
    if (v < `URT_BAUD_MIN) clamp_baud = `URT_BAUD_MIN;
    else if (v > `URT_BAUD_MAX) clamp_baud = `URT_BAUD_MAX;
    else clamp_baud = v;
  endfunction

  // ==========================================================
  // Configuration decode
  assign mode     = urt_mode_t'(ctrl_ff[`URT_CTRL_MODE]); // R1
  assign flow     = (mode == URT_RS232) ?
                    urt_flow_t'(ctrl_ff[`URT_CTRL_FLOW]) :
                    URT_FLOW_NONE; // R5
  assign tog      = (flow == URT_FLOW_TOGGLE); // R5
  assign cts_ok   = (flow != URT_FLOW_RTSCTS) || cts_s2_ff; // R10
  assign ptype    = urt_par_t'(ctrl_ff[`URT_CTRL_PAR]);
  assign last_bit = {1'b1, ctrl_ff[`URT_CTRL_DBITS]}; // R3
  assign two_wire = (mode == URT_RS485_2W);

  assign sel_ctrl = (addr == `URT_A_CTRL);
  assign sel_baud = (addr == `URT_A_BAUD);
  assign sel_dly  = (addr == `URT_A_RTSDLY);
  assign sel_tx   = (addr == `URT_A_TXDATA);
  assign sel_rx   = (addr == `URT_A_RXDATA);
  assign sel_st   = (addr == `URT_A_STATUS);

  // ==========================================================
  // Registers written by software
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl_ff    <= `URT_CTRL_RST;
      baud_ff    <= `URT_BAUD_RST;
      on_dly_ff  <= `URT_DLY_RST;
      off_dly_ff <= `URT_DLY_RST;
    end else if (wr_stb) begin
      if (sel_ctrl) ctrl_ff <= wdata[10:0];
      if (sel_baud) baud_ff <= clamp_baud(wdata[19:0]); // R2
      if (sel_dly) begin
        on_dly_ff  <= clamp_dly(wdata[`URT_DLY_ON]); // R9
        off_dly_ff <= clamp_dly(wdata[`URT_DLY_OFF]); // R9
      end
    end
  end

  // ==========================================================
  // Pin synchronisers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rxd_s1_ff <= 1'b1;
      rxd_s2_ff <= 1'b1;
      cts_s1_ff <= 1'b0;
      cts_s2_ff <= 1'b0;
    end else begin
      rxd_s1_ff <= rxd;
      rxd_s2_ff <= rxd_s1_ff;
      cts_s1_ff <= cts;
      cts_s2_ff <= cts_s1_ff;
    end
  end

  // ==========================================================
  // Buffers and bit clock
  assign tx_in.data   = wdata[7:0];
  assign tx_in.valid  = wr_stb && sel_tx;
  assign tx_out.ready = tx_pop;
  assign rx_in.data   = rx_sh_ff;
  assign rx_in.valid  = rx_push_ff;
  assign rx_out.ready = rd_stb && sel_rx;

  urt_fifo #(.W(8), .D(8)) u_tx_fifo (
    .clk    (clk),
    .nrst   (nrst),
    .single (!ctrl_ff[`URT_CTRL_FIFO]), // R4
    .in_s   (tx_in),
    .out_s  (tx_out)
  );

  urt_fifo #(.W(8), .D(8)) u_rx_fifo (
    .clk    (clk),
    .nrst   (nrst),
    .single (!ctrl_ff[`URT_CTRL_FIFO]), // R4
    .in_s   (rx_in),
    .out_s  (rx_out)
  );

  urt_baud u_baud (
    .clk     (clk),
    .nrst    (nrst),
    .rate    (baud_ff),
    .tick_ff (tick)
  );

  // ==========================================================
  // Transmitter
  assign tx_bit_end = tick && (tx_ovs_ff == `URT_OVS_LAST);
  assign tx_act = (nxt_tx_st == TX_START) || (nxt_tx_st == TX_DATA) ||
                  (nxt_tx_st == TX_PAR) || (nxt_tx_st == TX_STOP);

  always_comb begin
    nxt_tx_st  = tx_st_ff;
    nxt_tx_sh  = tx_sh_ff;
    nxt_tx_bit = tx_bit_ff;
    nxt_tx_ovs = tick ? tx_ovs_ff + 4'h1 : tx_ovs_ff;
    nxt_tx_par = tx_par_ff;
    nxt_tx_stp = tx_stp_ff;
    nxt_ms     = ms_ff;
    nxt_cyc    = cyc_ff;
    nxt_rtog   = rtog_ff;
    nxt_txd    = txd;
    tx_pop     = 1'b0;
    // Millisecond countdown shared by both RTS delays
    if ((tx_st_ff == TX_RTS_ON || tx_st_ff == TX_RTS_OFF) &&
        ms_ff != 7'h00) begin
      nxt_cyc = cyc_ff + 18'h00001;
      if (cyc_ff == 18'(MS_CYC - 1)) begin
        nxt_cyc = '0;
        nxt_ms  = ms_ff - 7'h01;
      end
    end
    case (tx_st_ff)
      TX_IDLE: begin
        nxt_txd  = 1'b1;
        nxt_rtog = 1'b0; // R8
        if (tx_out.valid && cts_ok) begin // R10
          if (tog) begin
            nxt_rtog  = 1'b1; // R6
            nxt_ms    = on_dly_ff; // R6
            nxt_cyc   = '0;
            nxt_tx_st = TX_RTS_ON;
          end else begin
            tx_pop     = 1'b1;
            nxt_tx_sh  = tx_out.data;
            nxt_tx_par = par_bit(tx_out.data, last_bit, ptype);
            nxt_tx_ovs = 4'h0;
            nxt_txd    = 1'b0;
            nxt_tx_st  = TX_START;
          end
        end
      end
      TX_RTS_ON: begin
        if (ms_ff == 7'h00) begin // R6
          tx_pop     = 1'b1;
          nxt_tx_sh  = tx_out.data;
          nxt_tx_par = par_bit(tx_out.data, last_bit, ptype);
          nxt_tx_ovs = 4'h0;
          nxt_txd    = 1'b0;
          nxt_tx_st  = TX_START;
        end
      end
      TX_START: begin
        if (tx_bit_end) begin
          nxt_txd    = tx_sh_ff[0];
          nxt_tx_sh  = {1'b0, tx_sh_ff[7:1]};
          nxt_tx_bit = 3'h0;
          nxt_tx_st  = TX_DATA;
        end
      end
      TX_DATA: begin
        if (tx_bit_end) begin
          if (tx_bit_ff == last_bit) begin // R3
            nxt_tx_stp = ctrl_ff[`URT_CTRL_STOP2]; // R3
            if (ptype != URT_PAR_NONE) begin
              nxt_txd   = tx_par_ff;
              nxt_tx_st = TX_PAR;
            end else begin
              nxt_txd   = 1'b1;
              nxt_tx_st = TX_STOP;
            end
          end else begin
            nxt_txd    = tx_sh_ff[0];
            nxt_tx_sh  = {1'b0, tx_sh_ff[7:1]};
            nxt_tx_bit = tx_bit_ff + 3'h1;
          end
        end
      end
      TX_PAR: begin
        if (tx_bit_end) begin
          nxt_txd   = 1'b1;
          nxt_tx_st = TX_STOP;
        end
      end
      TX_STOP: begin
        if (tx_bit_end) begin
          if (tx_stp_ff) begin
            nxt_tx_stp = 1'b0;
          end else if (rtog_ff && tx_out.valid) begin
            // Back-to-back characters keep RTS up
            tx_pop     = 1'b1;
            nxt_tx_sh  = tx_out.data;
            nxt_tx_par = par_bit(tx_out.data, last_bit, ptype);
            nxt_tx_ovs = 4'h0;
            nxt_txd    = 1'b0;
            nxt_tx_st  = TX_START;
          end else if (rtog_ff) begin
            nxt_ms    = off_dly_ff; // R7
            nxt_cyc   = '0;
            nxt_tx_st = TX_RTS_OFF;
          end else begin
            nxt_tx_st = TX_IDLE;
          end
        end
      end
      TX_RTS_OFF: begin
        if (ms_ff == 7'h00) begin
          nxt_rtog  = 1'b0; // R7
          nxt_tx_st = TX_IDLE;
        end
      end
      default: nxt_tx_st = TX_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      tx_st_ff  <= TX_IDLE;
      tx_sh_ff  <= '0;
      tx_bit_ff <= '0;
      tx_ovs_ff <= '0;
      tx_par_ff <= 1'b0;
      tx_stp_ff <= 1'b0;
      ms_ff     <= '0;
      cyc_ff    <= '0;
      rtog_ff   <= 1'b0;
    end else begin
      tx_st_ff  <= nxt_tx_st;
      tx_sh_ff  <= nxt_tx_sh;
      tx_bit_ff <= nxt_tx_bit;
      tx_ovs_ff <= nxt_tx_ovs;
      tx_par_ff <= nxt_tx_par;
      tx_stp_ff <= nxt_tx_stp;
      ms_ff     <= nxt_ms;
      cyc_ff    <= nxt_cyc;
      rtog_ff   <= nxt_rtog;
    end
  end

  // ==========================================================
  // Receiver; a two-wire bus hears its own echo, so it is muted
  assign rx_line = rxd_s2_ff || rx_en_n;
  assign rx_mid  = tick && (rx_ovs_ff == `URT_OVS_LAST);

  always_comb begin
    nxt_rx_st   = rx_st_ff;
    nxt_rx_sh   = rx_sh_ff;
    nxt_rx_bit  = rx_bit_ff;
    nxt_rx_ovs  = tick ? rx_ovs_ff + 4'h1 : rx_ovs_ff;
    nxt_rx_push = 1'b0;
    rx_perr     = 1'b0;
    rx_ferr     = 1'b0;
    case (rx_st_ff)
      RX_IDLE: begin
        nxt_rx_ovs = 4'h0;
        if (!rx_line) nxt_rx_st = RX_START;
      end
      RX_START: begin
        if (tick && rx_ovs_ff == `URT_OVS_MID) begin
          nxt_rx_ovs = 4'h0;
          nxt_rx_sh  = '0;
          nxt_rx_bit = 3'h0;
          nxt_rx_st  = rx_line ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA: begin
        if (rx_mid) begin
          nxt_rx_sh[rx_bit_ff] = rx_line;
          nxt_rx_bit = rx_bit_ff + 3'h1;
          if (rx_bit_ff == last_bit) begin // R3
            nxt_rx_st = (ptype != URT_PAR_NONE) ? RX_PAR : RX_STOP;
          end
        end
      end
      RX_PAR: begin
        if (rx_mid) begin
          rx_perr   = rx_line != par_bit(rx_sh_ff, last_bit, ptype);
          nxt_rx_st = RX_STOP;
        end
      end
      RX_STOP: begin
        if (rx_mid) begin
          rx_ferr     = !rx_line;
          nxt_rx_push = 1'b1;
          nxt_rx_st   = RX_IDLE;
        end
      end
      default: nxt_rx_st = RX_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rx_st_ff   <= RX_IDLE;
      rx_sh_ff   <= '0;
      rx_bit_ff  <= '0;
      rx_ovs_ff  <= '0;
      rx_push_ff <= 1'b0;
    end else begin
      rx_st_ff   <= nxt_rx_st;
      rx_sh_ff   <= nxt_rx_sh;
      rx_bit_ff  <= nxt_rx_bit;
      rx_ovs_ff  <= nxt_rx_ovs;
      rx_push_ff <= nxt_rx_push;
    end
  end

  // ==========================================================
  // Sticky status; a new event wins over a clear
  assign nxt_ovr  = (rx_push_ff && !rx_in.ready) ||
                    (ovr_ff && !(wr_stb && sel_st && wdata[3]));
  assign nxt_perr = rx_perr || (perr_ff && !(wr_stb && sel_st && wdata[4]));
  assign nxt_ferr = rx_ferr || (ferr_ff && !(wr_stb && sel_st && wdata[5]));
  assign nxt_drop = (tx_in.valid && !tx_in.ready) ||
                    (drop_ff && !(wr_stb && sel_st && wdata[8]));

  always_comb begin
    rd_mux = '0;
    case (1'b1)
      sel_ctrl: rd_mux = {21'h000000, ctrl_ff};
      sel_baud: rd_mux = {12'h000, baud_ff};
      sel_dly:  rd_mux = {9'h000, off_dly_ff, 9'h000, on_dly_ff};
      sel_rx:   rd_mux = {23'h000000, rx_out.valid, rx_out.data};
      sel_st:   rd_mux = {23'h000000, drop_ff, cts_s2_ff, rts, ferr_ff,
                          perr_ff, ovr_ff, rx_out.valid,
                          (tx_st_ff != TX_IDLE), tx_in.ready};
      default:  rd_mux = '0;
    endcase
  end

  // ==========================================================
  // Registered outputs
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ovr_ff    <= 1'b0;
      perr_ff   <= 1'b0;
      ferr_ff   <= 1'b0;
      drop_ff   <= 1'b0;
      rdata     <= '0;
      txd       <= 1'b1;
      txd_oe_n  <= 1'b0;
      rts       <= 1'b0;
      rx_en_n   <= 1'b0;
      line_mode <= 2'h0;
    end else begin
      ovr_ff    <= nxt_ovr;
      perr_ff   <= nxt_perr;
      ferr_ff   <= nxt_ferr;
      drop_ff   <= nxt_drop;
      rdata     <= rd_stb ? rd_mux : 32'h00000000;
      txd       <= nxt_txd;
      txd_oe_n  <= two_wire && !tx_act; // R1
      rx_en_n   <= two_wire && tx_act; // R1
      line_mode <= mode; // R1
      case (flow)
        URT_FLOW_TOGGLE: rts <= nxt_rtog; // R6 R7 R8
        URT_FLOW_RTSCTS: rts <= rx_in.ready;
        default:         rts <= (mode == URT_RS232);
      endcase
    end
  end
endmodule // urt_port

// ---- test/urt_port_props.sv ----
/*
 * Pin-level assertions for the serial port.
 * Assumes binding to urt_port; delays change only while idle.
 */
`timescale 1ns/1ps
`include "urt_defines.svh"
module urt_port_props #(
  parameter int MS_CYC = 20
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        nrst,
  // Register port
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr_stb,
  // Serial pins
  input wire logic        cts,
  input wire logic        txd,
  input wire logic        txd_oe_n,
  input wire logic        rts,
  input wire logic [1:0]  line_mode
);
  // ==========================================================
  // Helper state
  localparam int FRAME_MAX = 3000; // Longest frame at bench rate
  logic       tog_ff, rc_ff, sent_ff;
  logic [6:0] on_ff, off_ff;
  int         rts_cnt_ff, hi_cnt_ff, lo_cnt_ff;
  wire        ctrl_wr = wr_stb && addr == `URT_A_CTRL;
  always_ff @(posedge clk) begin
    if (!nrst || ctrl_wr) begin
      tog_ff  <= nrst && wdata[3:0] == 4'h8;
      rc_ff   <= nrst && wdata[3:0] == 4'h4;
      sent_ff <= 1'h0;
    end else if (tog_ff && $fell(txd)) begin
      sent_ff <= 1'h1;
    end
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      on_ff  <= 7'h00;
      off_ff <= 7'h00;
    end else if (wr_stb && addr == `URT_A_RTSDLY) begin
      on_ff  <= wdata[6:0];
      off_ff <= wdata[22:16];
    end
  end
  // Counters count up only while rts is high, txd is high or cts is low, and clear to zero otherwise
  always_ff @(posedge clk) begin
    rts_cnt_ff <= (nrst && rts) ? rts_cnt_ff + 1 : 0;
    hi_cnt_ff  <= (nrst && txd) ? hi_cnt_ff + 1 : 0;
    lo_cnt_ff  <= (nrst && !cts) ? lo_cnt_ff + 1 : 0;
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  chk_mode_follow: assert property (
    ctrl_wr |-> ##2 line_mode == $past(wdata[1:0], 2))
    else $error("line mode does not follow control write");
  chk_oe_full: assert property (
    line_mode != 2'h2 && $past(line_mode) != 2'h2 |-> !txd_oe_n)
    else $error("driver off outside two-wire mode");
  chk_oe_halfdup: assert property (
    line_mode == 2'h2 && txd_oe_n |-> txd)
    else $error("two-wire line sends while driver off");
  chk_rts_rs232: assert property (
    line_mode != 2'h0 && $past(line_mode) != 2'h0 |-> !rts)
    else $error("rts active outside RS-232 mode");
  chk_tx_needs_rts: assert property (
    tog_ff && !rts |-> txd)
    else $error("toggle mode sends with rts low");
  chk_on_delay: assert property (
    tog_ff && $fell(txd) |-> rts_cnt_ff >= on_ff * MS_CYC)
    else $error("start bit before on delay ran out");
  chk_off_delay: assert property (
    tog_ff && sent_ff && $fell(rts) |-> hi_cnt_ff >= off_ff * MS_CYC)
    else $error("rts dropped before off delay ran out");
  chk_cts_blocks: assert property (
    rc_ff && lo_cnt_ff > FRAME_MAX |-> txd)
    else $error("character sent while cts held low");
endmodule // urt_port_props

// ---- test/urt_dev_model.sv ----
/*
 * Far-end serial device: receives frames on txd, sends on rxd.
 * Assumes no parity, one stop bit and the bit time it is given.
 */
`timescale 1ns/1ps
module urt_dev_model #(
  parameter int BIT = 217
) (
  // Clock
  input  wire logic       clk,
  // Line
  input  wire logic       txd,
  output logic            rxd,
  output logic            cts,
  // Bench control
  input  wire logic       hold,
  input  wire logic [3:0] nbits,
  // Received character
  output logic [7:0]      got,
  output logic            got_v
);
  // ==========================================================
  // Slow partner holds clear-to-send off
  assign cts = !hold;
  initial begin
    rxd   = 1'h1;
    got   = 8'h00;
    got_v = 1'h0;
  end
  // ==========================================================
  // Receiver samples mid-bit; framing must match the port
  always begin
    @(negedge txd);
    repeat (BIT / 2) @(posedge clk);
    got = 8'h00;
    for (int i = 0; i < nbits; i++) begin
      repeat (BIT) @(posedge clk);
      got[i] = txd;
    end
    repeat (BIT) @(posedge clk);
    got_v = 1'h1;
    @(posedge clk);
    got_v = 1'h0;
  end
  // Sender: start, eight bits LSB first, one stop
  task send(input logic [7:0] b);
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      rxd <= (i == 0) ? 1'h0 : (i == 9) ? 1'h1 : b[(i + 7) % 8];
      repeat (BIT - 1) @(posedge clk);
    end
  endtask
endmodule // urt_dev_model

// ---- test/tb_uart_with_rts_toggle.sv ----
/*
 * Self-checking bench for the serial port.
 * Assumes urt_port, urt_dev_model and urt_port_props.
 */
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin \
  err_count++; $display("CHECK FAILED %s exp %h got %h", nm, e, s); \
  end end
module tb_uart_with_rts_toggle;
  // ==========================================================
  // Signals
  logic        clk, nrst, wr_stb, rd_stb, rd_d, rxd, cts, hold;
  logic        txd, txd_oe_n, rts, rx_en_n, got_v;
  logic [7:0]  addr, got, t, b0, b1;
  logic [31:0] wdata, rdata, e, m, seed;
  logic [1:0]  line_mode;
  logic [3:0]  nb;
  logic [31:0] rq[$], mq[$];
  logic [7:0]  tq[$];
  int          err_count, n_compared;
  urt_port #(.MS_CYC(20)) urt_port_inst (.clk(clk), .nrst(nrst),
    .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rdata(rdata), .rxd(rxd), .cts(cts), .txd(txd),
    .txd_oe_n(txd_oe_n), .rts(rts), .rx_en_n(rx_en_n),
    .line_mode(line_mode));
  urt_dev_model #(.BIT(217)) urt_dev_model_inst (.clk(clk),
    .txd(txd), .rxd(rxd), .cts(cts), .hold(hold), .nbits(nb),
    .got(got), .got_v(got_v));
  always #2.5 clk = ~clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // ==========================================================
  // Bus tasks
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'h1;
    @(posedge clk);
    wr_stb <= 1'h0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] k);
    rq.push_back(x);
    mq.push_back(k);
    @(posedge clk);
    addr   <= a;
    rd_stb <= 1'h1;
    @(posedge clk);
    rd_stb <= 1'h0;
  endtask
  task bw(input logic w_rts);
    for (int i = 0; i < 40000 && (tq.size() != 0 || (w_rts && rts)); i++)
      @(posedge clk);
    if (tq.size() != 0 || (w_rts && rts)) err_count++;
  endtask
  task results();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ==========================================================
  // Monitors
  always @(posedge clk) begin
    if (rd_d) begin
      e = rq.pop_front();
      m = mq.pop_front();
      `CHK("rdata", e, rdata & m)
    end
    rd_d <= rd_stb;
  end
  always @(posedge got_v) begin
    t = tq.size() != 0 ? tq.pop_front() : 8'hXX;
    `CHK("serial char", t, got)
    `CHK("rx_en_n", 1'h0, rx_en_n)
  end
  initial begin
    #500000;
    err_count++;
    results();
  end
  // ==========================================================
  // Stimulus
  initial begin
    {clk, nrst, wr_stb, rd_stb, rd_d, hold} = 6'h00;
    {addr, wdata, nb, seed} = {8'h00, 32'h0, 4'h8, 32'h6E7A5E1D};
    repeat (12) @(posedge clk);
    nrst <= 1'h1;
    rd(8'h00, 32'h430, 32'hFFFFFFFF);
    rd(8'h04, 32'h2580, 32'hFFFFFFFF);
    rd(8'h20, 32'h0, 32'hFFFFFFFF);
    wr(8'h04, 32'h64);
    rd(8'h04, 32'h12C, 32'hFFFFFFFF);
    seed = lfsr(seed);
    wr(8'h04, 32'd300 + seed % 32'd921301);
    rd(8'h04, 32'd300 + seed % 32'd921301, 32'hFFFFFFFF);
    for (int i = 0; i < 4; i++)
      wr(8'h00, 32'h400 | i);
    wr(8'h00, 32'h409);
    rd(8'h00, 32'h409, 32'hFFFFFFFF);
    wr(8'h04, 32'hE1000);
    wr(8'h08, 32'h007F007F);
    rd(8'h08, 32'h00640064, 32'hFFFFFFFF);
    wr(8'h08, 32'h00140002);
    wr(8'h00, 32'h438);
    for (int i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      tq.push_back(seed[7:0]);
      wr(8'h0C, seed);
    end
    bw(1'h1);
    rd(8'h14, 32'h0, 32'h40);
    nb = 4'h7;
    hold <= 1'h1;
    wr(8'h00, 32'h424);
    for (int i = 0; i < 9; i++) begin
      seed = lfsr(seed);
      if (i < 8)
        tq.push_back({1'h0, seed[6:0]});
      wr(8'h0C, seed);
    end
    repeat (4000) @(posedge clk);
    rd(8'h14, 32'h100, 32'h103);
    hold <= 1'h0;
    bw(1'h0);
    nb = 4'h8;
    wr(8'h00, 32'h430);
    {b0, b1} = 16'(lfsr(seed));
    urt_dev_model_inst.send(b0);
    urt_dev_model_inst.send(b1);
    repeat (4) @(posedge clk);
    rd(8'h10, {24'h1, b0}, 32'h1FF);
    rd(8'h10, {24'h1, b1}, 32'h1FF);
    wr(8'h00, 32'h030);
    urt_dev_model_inst.send(b1 ^ b0);
    repeat (4) @(posedge clk);
    rd(8'h10, {24'h1, b1 ^ b0}, 32'h1FF);
    repeat (4) @(posedge clk);
    results();
  end
endmodule // tb_uart_with_rts_toggle
bind urt_port urt_port_props #(.MS_CYC(MS_CYC)) urt_port_props_inst (
  .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
  .cts(cts), .txd(txd), .txd_oe_n(txd_oe_n), .rts(rts),
  .line_mode(line_mode));
